/* src/acm_ctrl.sv */
/*
 * Converter/comparator mode control with Wishbone register slave, done flag,
 * result transfer, shared upper port pins and comparator result capture.
 * Assumes classic Wishbone master, analog front end outside giving result
 * bits and comparator outputs asynchronously.
 */
`timescale 1ns/1ps
module acm_ctrl
    import acm_pkg::*;
#(
    parameter int unsigned RESP_CYC = CMP_RESP_CYC,
    parameter int unsigned CONV_LEN = CONV_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [9:0]  adc_result_in,
    input  wire logic [1:0]  comparator_out,
    input  wire logic        ram_backup,
    input  wire logic [3:0]  port_four_pins_i,
    output logic      [3:0]  port_four_pins_o,
    output logic      [3:0]  port_four_pins_oe,
    output logic      [3:0]  analog_in_upper_sel,
    output logic      [1:0]  comparator_power,
    output logic             conv_start,
    output logic             converter_busy,
    output logic             irq
);
    acm_wb_req_s req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    logic [3:0]  converter_ctrl_two;
    logic [3:0]  comparator_ctrl;
    logic [3:0]  irq_ctrl_two;
    logic [3:0]  port_four_latch;
    logic [3:0]  acc;
    logic [9:0]  result;
    logic        conversion_done_flag;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] int_en;
    logic [1:0]  cmp_result;
    logic [7:0]  conv_cnt;
    acm_state_e  state;
    acm_state_e  next_state;

    logic [1:0]  cmp_sync;
    logic [3:0]  pin_sync;
    logic        cmp_ready;
    logic        cmp_ready_pulse;

    acm_sync #(.W(2)) u_cmp_sync
    (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .din     (comparator_out),
        .dout    (cmp_sync)
    );

    // port pins are asynchronous to ref_clk
    acm_sync #(.W(4)) u_pin_sync
    (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .din     (port_four_pins_i),
        .dout    (pin_sync)
    );

    // comparators keep running through ram back-up: power is register only
    assign comparator_power = {comparator_ctrl[CMP_EN1_BIT], comparator_ctrl[CMP_EN0_BIT]}; // (R8) (R9)

    acm_cmp_timer #(.RESP_CYC(RESP_CYC)) u_cmp_timer
    (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .enables     (comparator_power),
        .ready       (cmp_ready),
        .ready_pulse (cmp_ready_pulse)
    );

    // bus decode
    wire access   = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    wire wr       = access && req.we && req.sel[0];
    wire hit_conv = req.adr == OFS_CONV_CTRL_TWO;
    wire hit_cmp  = req.adr == OFS_CMP_CTRL;
    wire hit_irq  = req.adr == OFS_IRQ_CTRL_TWO;
    wire hit_res  = req.adr == OFS_RESULT;
    wire hit_cmd  = req.adr == OFS_CMD;
    wire hit_acc  = req.adr == OFS_ACC;
    wire hit_port = req.adr == OFS_PORT_FOUR;
    wire hit_stat = req.adr == OFS_STATUS;
    wire hit_ien  = req.adr == OFS_INT_EN;
    wire hit_iclr = req.adr == OFS_INT_CLR;
    wire mapped   = hit_conv | hit_cmp | hit_irq | hit_res | hit_cmd | hit_acc
                  | hit_port | hit_stat | hit_ien | hit_iclr;

    wire wr_conv  = wr && hit_conv;
    wire wr_cmd   = wr && hit_cmd;
    wire cmd_start = wr_cmd && req.dat[CMD_START_BIT];
    wire cmd_skip  = wr_cmd && req.dat[CMD_SKIP_BIT];
    wire cmd_move  = wr_cmd && req.dat[CMD_MOVE_BIT];

    // mode bit low = conversion, high = comparator
    wire comparator_mode  = converter_ctrl_two[MODE_BIT];
    wire next_mode        = req.dat[MODE_BIT];
    wire to_conversion    = wr_conv && comparator_mode && !next_mode; // (R3)
    // comparator-to-conversion switch raises the done flag just as a finished conversion would
    wire spurious_done    = to_conversion; // (R2)
    wire genuine_done     = state == ACM_DONE;
    wire set_done         = genuine_done || spurious_done; // (R12)
    wire busy             = state == ACM_CONV;

    // start is honoured only in conversion mode and while idle
    always_comb
    begin
        next_state = state;
        unique case (state)
            ACM_IDLE: if (cmd_start && !comparator_mode) next_state = ACM_CONV;
            ACM_CONV: if (conv_cnt == 8'(CONV_LEN - 1)) next_state = ACM_DONE;
            ACM_DONE: next_state = ACM_IDLE;
            default:  next_state = ACM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state    <= ACM_IDLE;
            conv_cnt <= 8'h00;
        end
        // counter restarts on every entry to the conversion state
        else if (clk_en)
        begin
            state    <= next_state;
            conv_cnt <= busy ? conv_cnt + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            result <= 10'h000;
        end
        // sampled once, in the cycle after the last busy cycle
        else if (clk_en && genuine_done)
        begin
            result <= adc_result_in;
        end
    end

    // mode bit is simply written; a write during a conversion is a software fault
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            converter_ctrl_two <= CONV_CTRL_RST;
            irq_ctrl_two       <= IRQ_CTRL_RST;
            port_four_latch    <= PORT_FOUR_RST;
        end
        else if (clk_en)
        begin
            if (wr_conv)
                converter_ctrl_two <= req.dat[3:0]; // (R3) (R4)
            if (wr && hit_irq)
                irq_ctrl_two <= req.dat[3:0]; // (R1)
            if (wr && hit_port)
                port_four_latch <= req.dat[3:0]; // (R6)
        end
    end

    // only enable bits are writable; result bits come from the comparators
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            comparator_ctrl <= CMP_CTRL_RST;
        end
        else if (clk_en)
        begin
            if (wr && hit_cmp)
                comparator_ctrl[3:2] <= req.dat[3:2]; // (R9) (R10)
            comparator_ctrl[1:0] <= cmp_result; // (R10)
        end
    end

    // results read zero until response time has passed after enabling
    wire [1:0] next_cmp_result = cmp_ready ? (cmp_sync & comparator_power) : 2'b00; // (R11)

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            cmp_result <= 2'b00;
        else if (clk_en)
            cmp_result <= next_cmp_result;
    end

    // set wins over skip-clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            conversion_done_flag <= 1'b0;
        else if (clk_en)
            conversion_done_flag <= set_done || (conversion_done_flag && !cmd_skip); // (R2) (R12)
    end

    // result transfer: low result bits to accumulator top, low bits zero
    wire [3:0] next_acc = cmd_move ? {result[1:0], 2'b00}
                        : (wr && hit_acc) ? req.dat[3:0] : acc; // (R5)

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            acc <= 4'h0;
        else if (clk_en)
            acc <= next_acc;
    end

    // sticky events; set beats clear
    wire [EV_W-1:0] events = {cmp_ready_pulse, spurious_done, genuine_done};
    wire [EV_W-1:0] clr    = (wr && hit_iclr) ? req.dat[EV_W-1:0] : '0;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status <= '0;
            int_en <= INT_EN_RST;
        end
        else if (clk_en)
        begin
            status <= events | (status & ~clr);
            if (wr && hit_ien)
                int_en <= req.dat[EV_W-1:0];
        end
    end

    // done flag only requests an interrupt when the converter irq enable is set
    wire conv_irq = conversion_done_flag && irq_ctrl_two[CONV_IRQ_EN_BIT]; // (R1)
    assign irq = |(status & int_en) || conv_irq;

    // analog pins still drive their latch; software keeps those at 1
    assign analog_in_upper_sel = converter_ctrl_two; // (R6)
    assign port_four_pins_o    = port_four_latch; // (R6)
    assign port_four_pins_oe   = ~port_four_latch;
    assign conv_start          = state == ACM_IDLE && next_state == ACM_CONV;
    assign converter_busy      = busy;

    // analog-selected pins read back zero: value has no meaning there
    wire [3:0] port_read = pin_sync & ~analog_in_upper_sel; // (R7)

    // write-only clear register reads back zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit_conv: rd_mux[3:0] = converter_ctrl_two;
            hit_cmp:  rd_mux[3:0] = comparator_ctrl;
            hit_irq:  rd_mux[3:0] = irq_ctrl_two;
            hit_res:  rd_mux[9:0] = result;
            hit_cmd:  rd_mux[1:0] = {busy, conversion_done_flag};
            hit_acc:  rd_mux[3:0] = acc;
            hit_port: rd_mux[3:0] = port_read;
            hit_stat: rd_mux[EV_W-1:0] = status;
            hit_ien:  rd_mux[EV_W-1:0] = int_en;
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        // one wait state; the answer stands one cycle, and is held longer only while clk_en is low
        else if (clk_en)
        begin
            wb_ack_o <= access && mapped;
            wb_err_o <= access && !mapped;
            wb_dat_o <= (access && !req.we) ? rd_mux : 32'h0000_0000;
        end
    end

    // back-up level has no effect: comparators keep their register power
    wire unused_ok = ram_backup;
endmodule // acm_ctrl

/* inc/acm_pkg.sv */
/*
 * Constants, register offsets, field positions and carrier types for the
 * converter/comparator mode control block.
 * Assumes a classic Wishbone slave with 32-bit data on a 100 MHz ref_clk.
 */
// Behaviour
// (R1) software clears converter irq enable before switching comparator to conversion
// (R2) comparator-to-conversion switch may set done flag; software clears it by skip
// (R3) bit 3 of converter_ctrl_two at 0 selects conversion; other bits unaffected
// (R4) software never toggles mode bit while converter busy
// (R5) result transfer: result bits 1:0 to acc 3:2, acc 1:0 forced zero
// (R6) upper shared pins keep port function; analog pins should drive latch 1
// (R7) port input read from an analog-selected pin is undefined
// (R8) enabled comparator keeps running during RAM back-up
// (R9) comparator_ctrl bits 2 and 3 cleared disables the comparators
// (R10) comparator_ctrl bits 0 and 1 are read-only results
// (R11) software waits comparator response time, 20 us, before reading results
// (R12) spurious done flag stays set until skip-clear or reset
package acm_pkg;

    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned CMP_RESP_US       = 20;
    localparam int unsigned CMP_RESP_CYC      = CMP_RESP_US * CLK_MHZ;
    localparam int unsigned CONV_CYC          = 44;

    localparam logic [7:0]  OFS_CONV_CTRL_TWO = 8'h00;
    localparam logic [7:0]  OFS_CMP_CTRL      = 8'h04;
    localparam logic [7:0]  OFS_IRQ_CTRL_TWO  = 8'h08;
    localparam logic [7:0]  OFS_RESULT        = 8'h0C;
    localparam logic [7:0]  OFS_CMD           = 8'h10;
    localparam logic [7:0]  OFS_ACC           = 8'h14;
    localparam logic [7:0]  OFS_PORT_FOUR     = 8'h18;
    localparam logic [7:0]  OFS_STATUS        = 8'h1C;
    localparam logic [7:0]  OFS_INT_EN        = 8'h20;
    localparam logic [7:0]  OFS_INT_CLR       = 8'h24;

    localparam int unsigned MODE_BIT          = 3;
    localparam int unsigned CMP_EN0_BIT       = 2;
    localparam int unsigned CMP_EN1_BIT       = 3;
    localparam int unsigned CONV_IRQ_EN_BIT   = 2;
    localparam int unsigned CMD_START_BIT     = 0;
    localparam int unsigned CMD_SKIP_BIT      = 1;
    localparam int unsigned CMD_MOVE_BIT      = 2;

    localparam logic [3:0]  CONV_CTRL_RST     = 4'h0;
    localparam logic [3:0]  CMP_CTRL_RST      = 4'h0;
    localparam logic [3:0]  IRQ_CTRL_RST      = 4'h0;
    localparam logic [3:0]  PORT_FOUR_RST     = 4'hF;
    localparam logic [2:0]  INT_EN_RST        = 3'h0;

    localparam int unsigned EV_DONE           = 0;
    localparam int unsigned EV_SPURIOUS       = 1;
    localparam int unsigned EV_CMP_READY      = 2;
    localparam int unsigned EV_W              = 3;

    typedef enum logic [1:0]
    {
        ACM_IDLE = 2'b00,
        ACM_CONV = 2'b01,
        ACM_DONE = 2'b10
    } acm_state_e;

    typedef struct packed
    {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } acm_wb_req_s;

    typedef struct packed
    {
        logic [1:0] result;
        logic       ready;
    } acm_cmp_s;

endpackage

/* src/acm_sync.sv */
/*
 * Three-flop input synchroniser; output changes once stages two and three agree.
 * Assumes an asynchronous input and ref_clk domain.
 */
`timescale 1ns/1ps
module acm_sync
    import acm_pkg::*;
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire  [W-1:0] agree = ~(s2 ^ s3);
    wire  [W-1:0] next_dout = (agree & s3) | (~agree & dout);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            dout <= '0;
        end
        else if (clk_en)
        begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule // acm_sync

/* src/acm_cmp_timer.sv */
/*
 * Comparator response timer: signals ready a fixed time after enabling.
 * Assumes ref_clk at CLK_MHZ; restarts whenever the enable set changes.
 */
`timescale 1ns/1ps
module acm_cmp_timer
    import acm_pkg::*;
#(
    parameter int unsigned RESP_CYC = CMP_RESP_CYC
)
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic [1:0] enables,
    output logic            ready,
    output logic            ready_pulse
);
    logic [15:0] count;
    logic [1:0]  enables_q;
    wire         restart    = enables != enables_q;
    wire         at_end     = count == 16'(RESP_CYC - 1);
    wire         next_ready = !restart && (ready || at_end) && (enables != 2'b00);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count       <= 16'h0000;
            enables_q   <= 2'b00;
            ready       <= 1'b0;
            ready_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            enables_q   <= enables;
            count       <= (restart || ready) ? 16'h0000 : count + 16'h0001;
            ready       <= next_ready;
            ready_pulse <= next_ready && !ready;
        end
    end
endmodule // acm_cmp_timer

/* verification/acm_ctrl_sva.sv */
/*
 * Checker for acm_ctrl: bus timing, pin enables, mode and power registers.
 * Assumes one ref_clk domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
module acm_ctrl_chk
    import acm_pkg::*;
#(
    parameter int unsigned RESP_CYC = CMP_RESP_CYC,
    parameter int unsigned CONV_LEN = CONV_CYC
)
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        ram_backup,
    input wire logic [3:0]  port_four_pins_o,
    input wire logic [3:0]  port_four_pins_oe,
    input wire logic [3:0]  analog_in_upper_sel,
    input wire logic [1:0]  comparator_power,
    input wire logic        conv_start,
    input wire logic        converter_busy,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic wr0 = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire logic adr_mapped = wb_adr_i inside {OFS_CONV_CTRL_TWO, OFS_CMP_CTRL, OFS_IRQ_CTRL_TWO, OFS_RESULT,
                                             OFS_CMD, OFS_ACC, OFS_PORT_FOUR, OFS_STATUS, OFS_INT_EN, OFS_INT_CLR};
    logic [15:0] busy_cnt;
    // counts busy cycles, too long for a repetition
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            busy_cnt <= 16'h0000;
        else if (clk_en)
            busy_cnt <= converter_busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
    a_ack_one_cycle: assert property (req && !wb_ack_o && !wb_err_o && clk_en |=> (wb_ack_o || wb_err_o))
        else $error("no answer one cycle after request");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_rdata_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_oe_inverse_latch: assert property (port_four_pins_oe == ~port_four_pins_o)
        else $error("pin enable not inverse of latch");
    a_power_write: assert property (wr0 && wb_adr_i == OFS_CMP_CTRL |=> comparator_power == $past(wb_dat_i[3:2]))
        else $error("comparator enables not written");
    a_mode_write: assert property (wr0 && wb_adr_i == OFS_CONV_CTRL_TWO |=> analog_in_upper_sel == $past(wb_dat_i[3:0]))
        else $error("converter control not written");
    a_backup_keeps_power: assert property (ram_backup && !req |=> $stable(comparator_power))
        else $error("back-up changed comparator power");
    a_start_when_idle: assert property (conv_start |-> !converter_busy ##1 converter_busy)
        else $error("start while busy or without busy");
    a_conv_length: assert property ($fell(converter_busy) |-> busy_cnt == 16'(CONV_LEN))
        else $error("conversion length wrong");
    a_err_unmapped: assert property ($rose(wb_err_o) |-> !$past(adr_mapped))
        else $error("error on mapped address");
    c_conv: cover property (conv_start);
    c_irq: cover property ($rose(irq));
    c_err: cover property (wb_err_o);
endmodule // acm_ctrl_chk

bind acm_ctrl acm_ctrl_chk #(.RESP_CYC(RESP_CYC), .CONV_LEN(CONV_LEN)) chk_u (.*);

/* verification/acm_analog_model.sv */
/*
 * Far-side model: upper port pins, converter result and comparator outputs.
 * Assumes the bench sets the external levels.
 */
`timescale 1ns/1ps
module acm_analog_model
    import acm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [3:0] port_o,
    input  wire logic [3:0] port_oe,
    input  wire logic [3:0] analog_sel,
    input  wire logic [1:0] power,
    input  wire logic       busy,
    input  wire logic [3:0] lvl_pin,
    input  wire logic [9:0] lvl_adc,
    input  wire logic [1:0] lvl_cmp,
    output logic      [3:0] pins,
    output logic      [9:0] adc_result,
    output logic      [1:0] cmp_out
);
    logic tgl  = 1'b0;
    logic hold = 1'b0;
    always @(posedge ref_clk)
    begin
        tgl  <= ~tgl;
        hold <= busy;
    end
    // released analog pins give no usable digital level
    assign pins = (port_oe & port_o) | (~port_oe & ~analog_sel & lvl_pin) | (~port_oe & analog_sel & {4{tgl}});
    assign adc_result = (busy | hold) ? lvl_adc : ~lvl_adc;
    // unpowered comparators output noise; back-up does not stop them
    assign cmp_out = (power & lvl_cmp) | (~power & {2{tgl}});
endmodule // acm_analog_model

/* verification/test_adc_comparator_mode_control.sv */
/*
 * Bench for acm_ctrl: random and corner register traffic over Wishbone.
 * Assumes acm_analog_model on the far side and the bound checker.
 */
`timescale 1ns/1ps
module test_adc_comparator_mode_control;
    import acm_pkg::*;
    localparam int unsigned RC = 20;
    logic              ref_clk = 1'b0;
    logic              arst_n  = 1'b0;
    logic              bk      = 1'b0;
    logic              ce      = 1'b1;
    logic              e;
    logic [3:0]        pl      = 4'h0;
    logic [9:0]        al      = 10'h000;
    logic [1:0]        cl      = 2'b00;
    logic [7:0]        v;
    logic [31:0]       q;
    logic [31:0]       ac;
    acm_wb_req_s       rq      = '0;
    wire logic [31:0]  dato;
    wire logic         ack, err, cs, busy, irq;
    wire logic [3:0]   po, poe, asel, pin;
    wire logic [1:0]   pw, cmpo;
    wire logic [9:0]   adcr;
    int                num_errors  = 0;
    int                comparisons = 0;
    int                seed        = 4;
    int                i;

    always #5 ref_clk = ~ref_clk;

    acm_ctrl #(.RESP_CYC(RC), .CONV_LEN(8)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce),
        .wb_cyc_i(rq.cyc), .wb_stb_i(rq.stb), .wb_we_i(rq.we), .wb_sel_i(rq.sel), .wb_adr_i(rq.adr),
        .wb_dat_i(rq.dat), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err), .adc_result_in(adcr),
        .comparator_out(cmpo), .ram_backup(bk), .port_four_pins_i(pin), .port_four_pins_o(po),
        .port_four_pins_oe(poe), .analog_in_upper_sel(asel), .comparator_power(pw), .conv_start(cs),
        .converter_busy(busy), .irq(irq));
    acm_analog_model far_u (.ref_clk(ref_clk), .port_o(po), .port_oe(poe), .analog_sel(asel), .power(pw),
        .busy(busy), .lvl_pin(pl), .lvl_adc(al), .lvl_cmp(cl), .pins(pin), .adc_result(adcr), .cmp_out(cmpo));

    function automatic logic [31:0] exp_move(input logic [9:0] r, input logic [31:0] a);
        return {28'h000_0000, r[1:0], 2'b00};
    endfunction

    function automatic logic [31:0] exp_pin(input logic [3:0] lat, input logic [3:0] lv, input logic [3:0] an);
        return {28'h000_0000, lat & lv & ~an};
    endfunction

    task automatic conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        rq <= '{1'b1, 1'b1, w, 4'h1, a, d};
        for (n = 0; n < 50 && ack !== 1'b1 && err !== 1'b1; n++)
            @(posedge ref_clk);
        q = dato;
        e = err;
        rq <= '0;
        if (n == 50)
        begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h0000_0000);
        check(q, x);
    endtask

    task automatic idle;
        int n;
        repeat (2) @(posedge ref_clk);
        for (n = 0; n < 100 && busy !== 1'b0; n++)
            @(posedge ref_clk);
        if (n == 100)
        begin
            num_errors++;
            conclude();
        end
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        // released pins read the outside level, which is low here
        rchk(OFS_PORT_FOUR, exp_pin(PORT_FOUR_RST, pl, 4'h0));
        check({28'h000_0000, po}, {28'h000_0000, PORT_FOUR_RST});
        rchk(OFS_CONV_CTRL_TWO, 32'h0000_0000);
        rchk(OFS_CMP_CTRL, 32'h0000_0000);
        rchk(OFS_IRQ_CTRL_TWO, 32'h0000_0000);
        rchk(OFS_INT_EN, 32'h0000_0000);
        wb(1'b0, 8'h30, 32'h0000_0000);
        check(e, 1'b1);
        cl <= 2'b10;
        wb(1'b1, OFS_CMP_CTRL, 32'h0000_000F);
        rchk(OFS_CMP_CTRL, 32'h0000_000C);
        bk <= 1'b1;
        // result bits read only after the response time
        repeat (RC + 10) @(posedge ref_clk);
        rchk(OFS_CMP_CTRL, 32'h0000_000E);
        check(pw, 2'b11);
        wb(1'b1, OFS_CMP_CTRL, 32'h0000_0000);
        rchk(OFS_CMP_CTRL, 32'h0000_0000);
        bk <= 1'b0;
        repeat (RC + 10) @(posedge ref_clk);
        rchk(OFS_STATUS, 32'h0000_0004);
        wb(1'b1, OFS_INT_EN, 32'h0000_0004);
        rchk(OFS_INT_EN, 32'h0000_0004);
        check(irq, 1'b1);
        wb(1'b1, OFS_INT_EN, 32'h0000_0000);
        rchk(OFS_STATUS, 32'h0000_0004);
        check(irq, 1'b0);
        wb(1'b1, OFS_INT_CLR, 32'h0000_0007);
        rchk(OFS_STATUS, 32'h0000_0000);
        wb(1'b1, OFS_CONV_CTRL_TWO, 32'h0000_000F);
        wb(1'b1, OFS_IRQ_CTRL_TWO, 32'h0000_0000);
        wb(1'b1, OFS_CONV_CTRL_TWO, 32'h0000_0007);
        rchk(OFS_CONV_CTRL_TWO, 32'h0000_0007);
        rchk(OFS_CMD, 32'h0000_0001);
        repeat (30) @(posedge ref_clk);
        rchk(OFS_CMD, 32'h0000_0001);
        rchk(OFS_STATUS, 32'h0000_0002);
        check(irq, 1'b0);
        wb(1'b1, OFS_IRQ_CTRL_TWO, 32'h0000_0004);
        rchk(OFS_IRQ_CTRL_TWO, 32'h0000_0004);
        check(irq, 1'b1);
        wb(1'b1, OFS_CMD, 32'h0000_0002);
        rchk(OFS_CMD, 32'h0000_0000);
        check(irq, 1'b0);
        wb(1'b1, OFS_IRQ_CTRL_TWO, 32'h0000_0000);
        // mode bit left alone while converting
        for (i = 0; i < 4; i++)
        begin
            al <= (i == 0) ? 10'h3FF : 10'($random(seed));
            ac = 32'($random(seed)) & 32'h0000_000F;
            wb(1'b1, OFS_CMD, 32'h0000_0001);
            // clock enable low must freeze the conversion in mid-run
            if (i == 1)
            begin
                ce <= 1'b0;
                repeat (20) @(posedge ref_clk);
                check({31'h0000_0000, busy}, 32'h0000_0001);
                ce <= 1'b1;
            end
            idle();
            rchk(OFS_RESULT, {22'h00_0000, al});
            rchk(OFS_CMD, 32'h0000_0001);
            wb(1'b1, OFS_ACC, ac);
            wb(1'b1, OFS_CMD, 32'h0000_0004);
            rchk(OFS_ACC, exp_move(al, ac));
            wb(1'b1, OFS_CMD, 32'h0000_0002);
        end
        for (i = 0; i < 5; i++)
        begin
            v = (i == 0) ? 8'hF8 : 8'($random(seed));
            pl <= v[7:4];
            wb(1'b1, OFS_PORT_FOUR, {28'h000_0000, v[3:0]});
            repeat (5) @(posedge ref_clk);
            check(po, v[3:0]);
            rchk(OFS_PORT_FOUR, exp_pin(v[3:0], v[7:4], 4'h7));
        end
        conclude();
    end
endmodule // test_adc_comparator_mode_control
